//--- bench/wrc_ext_model.sv
// far-side model: reset pin driver, wake pins, boundary-scan tester
`timescale 1ns/1ps
module wrc_ext_model
	import wrc_pkg::*;
#(
	parameter int SCAN_WAIT_CYC = 50
)
(
	input  wire logic  clk,
	output logic       reset_pin_n,
	output logic [7:0] wake_pin_n,
	output logic       test_reset_n
);
	// ==========================================================
	// idle levels: pull-ups hold every line high
	initial
	begin
		reset_pin_n = 1'b1;
		wake_pin_n = 8'hff;
		test_reset_n = 1'b1;
	end

	task automatic press_wake(input int i);
		wake_pin_n <= ~(8'h1 << i);
	endtask

	// power-up high, wait, then pull low
	task automatic scan_enter();
		reset_pin_n <= 1'b1;
		repeat (SCAN_WAIT_CYC) @(posedge clk);
		reset_pin_n <= 1'b0;
		repeat (RST_PULSE_CYC + 2) @(posedge clk);
	endtask

	// test reset first, then release pin
	task automatic scan_exit();
		test_reset_n <= 1'b0;
		@(posedge clk);
		reset_pin_n <= 1'b1;
		@(posedge clk);
		test_reset_n <= 1'b1;
	endtask
endmodule

//--- bench/wrc_top_tb_top.sv
// bench for the wake-up and reset control block
`timescale 1ns/1ps
module wrc_top_tb_top
	import wrc_pkg::*;
;
	logic        clk = 1'b0;
	logic        resetn = 1'b0;
	logic [5:0]  avs_address = 6'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [1:0]  power_mode = 2'h0;
	logic [31:0] irq_pending = 32'h0;
	logic [31:0] irq_enable = 32'h0;
	logic [7:0]  pin_int = 8'h0;
	logic [2:0]  bo_below_int_level = 3'h0;
	logic        bo_below_rst_level = 1'b0;
	logic        wd_int = 1'b0;
	logic        wd_rst = 1'b0;
	logic        wkt_timeout = 1'b0;
	logic [2:0]  serial_int = 3'h0;
	logic [2:0]  serial_slave = 3'h0;
	logic        por_n = 1'b1;
	logic        ce = 1'b1;
	logic [1:0]  clk_stable = 2'h0;
	logic        reset_pin_n;
	logic [7:0]  wake_pin_n;
	logic        wake_core, chip_reset, fro_start, flash_init, bo_irq, jtag_bscan_en, swd_en;
	logic [31:0] fetch_addr;
	logic [1:0]  clk_select;
	logic [31:0] rd;
	int          err_total = 0;
	int          comparisons = 0;

	always #2.5 clk = ~clk;

	wrc_ext_model u_wrc_ext_model (.clk(clk), .reset_pin_n(reset_pin_n), .wake_pin_n(wake_pin_n),
		.test_reset_n());

	wrc_top u_wrc_top (.clk(clk), .resetn(resetn), .ce(ce), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.power_mode(power_mode), .irq_pending(irq_pending), .irq_enable(irq_enable),
		.pin_int(pin_int), .bo_below_int_level(bo_below_int_level),
		.bo_below_rst_level(bo_below_rst_level), .wd_int(wd_int), .wd_rst(wd_rst),
		.wkt_timeout(wkt_timeout), .serial_int(serial_int), .serial_slave(serial_slave),
		.wake_pin_n(wake_pin_n), .reset_pin_n(reset_pin_n), .por_n(por_n), .clk_stable(clk_stable),
		.wake_core(wake_core), .chip_reset(chip_reset), .fro_start(fro_start),
		.flash_init(flash_init), .fetch_addr(fetch_addr), .clk_select(clk_select),
		.bo_irq(bo_irq), .jtag_bscan_en(jtag_bscan_en), .swd_en(swd_en));

	task automatic wrap_up();
		$display("counts: %0d compared, %0d bad", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// ==========================================================
	// bus access: hold until waitrequest sampled low
	task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (avs_waitrequest !== 1'b0 && n < 50);
		rd = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n >= 50)
		begin
			err_total++;
			wrap_up();
		end
		@(posedge clk);
	endtask

	task automatic wait_rst();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (chip_reset !== 1'b0 && n < 100);
		if (n >= 100)
		begin
			err_total++;
			wrap_up();
		end
	endtask

	task automatic rst(input int cyc);
		resetn <= 1'b0;
		power_mode <= 2'h0;
		{irq_pending, irq_enable, pin_int, bo_below_int_level, bo_below_rst_level} <= '0;
		{wd_int, wd_rst, wkt_timeout, serial_int, serial_slave, clk_stable} <= '0;
		repeat (cyc) @(posedge clk);
		chk(chip_reset, 1'b1);
		chk({fro_start, flash_init}, 2'h3);
		chk(fetch_addr, BOOT_ADDR);
		chk(swd_en, 1'b0);
		resetn <= 1'b1;
		wait_rst();
		chk({chip_reset, fro_start, flash_init}, 3'h0);
	endtask

	task automatic wt(input logic e);
		repeat (6) @(posedge clk);
		chk(wake_core, e);
	endtask

	// ==========================================================
	// main sequence
	initial
	begin
		rst(8);
		chk(clk_select, RST_CLK_FRO);
		for (int a = 0; a < 'h34; a += 4)
		begin
			bus(1'b0, 6'(a), 32'h0);
			if (a != 'h24)
				chk(rd, RST_ZERO);
		end
		bus(1'b1, 6'h30, 32'hffffffff);
		bus(1'b0, 6'h30, 32'h0);
		chk(rd, 32'h0);
		bus(1'b1, ADDR_START1, 32'h3f);
		bus(1'b0, ADDR_START1, 32'h0);
		chk(rd, 32'h3f);
		$display("test registers done");

		power_mode <= 2'h1;
		irq_pending <= 32'h20;
		wt(1'b0);
		ce <= 1'b0;
		irq_enable <= 32'h20;
		wt(1'b0);
		ce <= 1'b1;
		wt(1'b1);
		rst(2);
		power_mode <= 2'h2;
		pin_int <= 8'h08;
		irq_pending <= 32'h08;
		irq_enable <= 32'h08;
		wt(1'b0);
		bus(1'b1, ADDR_START0, 32'h08);
		wt(1'b1);
		irq_enable <= 32'h0;
		wt(1'b0);
		$display("test sleep and pin wake done");

		rst(2);
		power_mode <= 2'h2;
		bus(1'b1, ADDR_START1, 32'h1);
		bus(1'b1, ADDR_BROWNOUT, 32'h5);
		irq_enable <= 32'h100;
		irq_pending <= 32'h100;
		bo_below_int_level <= 3'h1;
		wt(1'b0);
		bus(1'b1, ADDR_SLEEPCFG, 32'h1);
		wt(1'b1);
		chk(bo_irq, 1'b1);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h1, 32'h1);
		for (int lv = 1; lv < 4; lv++)
		begin
			bus(1'b1, ADDR_BROWNOUT, 32'(4 + lv));
			bo_below_int_level <= ~3'(1 << (lv - 1));
			repeat (4) @(posedge clk);
			chk(bo_irq, 1'b0);
			bo_below_int_level <= 3'(1 << (lv - 1));
			repeat (4) @(posedge clk);
			chk(bo_irq, 1'b1);
		end
		rst(2);
		power_mode <= 2'h2;
		bus(1'b1, ADDR_BROWNOUT, 32'h8);
		bo_below_rst_level <= 1'b1;
		repeat (4) @(posedge clk);
		chk(chip_reset, 1'b0);
		bus(1'b1, ADDR_SLEEPCFG, 32'h1);
		repeat (3) @(posedge clk);
		chk({chip_reset, fro_start, flash_init}, 3'h7);
		bo_below_rst_level <= 1'b0;
		wait_rst();
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h20, 32'h20);
		$display("test brownout done");

		rst(2);
		power_mode <= 2'h2;
		bus(1'b1, ADDR_START1, 32'h2);
		bus(1'b1, ADDR_SLEEPCFG, 32'h2);
		bus(1'b1, ADDR_WDMODE, 32'h5);
		irq_enable <= 32'h200;
		irq_pending <= 32'h200;
		wd_int <= 1'b1;
		wt(1'b0);
		bus(1'b1, ADDR_WDMODE, 32'hd);
		wt(1'b1);
		wd_int <= 1'b0;
		bus(1'b1, ADDR_WDMODE, 32'h1);
		wd_rst <= 1'b1;
		repeat (4) @(posedge clk);
		chk(chip_reset, 1'b0);
		bus(1'b1, ADDR_WDMODE, 32'h3);
		repeat (3) @(posedge clk);
		chk(chip_reset, 1'b1);
		wd_rst <= 1'b0;
		wait_rst();
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h8, 32'h8);
		$display("test watchdog done");

		rst(2);
		power_mode <= 2'h2;
		bus(1'b1, ADDR_START1, 32'h4);
		bus(1'b1, ADDR_LPCLKEN, 32'h1);
		bus(1'b1, ADDR_WKTCTRL, 32'h1);
		irq_enable <= 32'h400;
		irq_pending <= 32'h400;
		wkt_timeout <= 1'b1;
		wt(1'b0);
		bus(1'b1, ADDR_WKTCTRL, 32'h3);
		wt(1'b1);
		rst(2);
		power_mode <= 2'h2;
		bus(1'b1, ADDR_START1, 32'h8);
		bus(1'b1, ADDR_PERIPH, 32'h1);
		irq_enable <= 32'h800;
		irq_pending <= 32'h800;
		serial_int <= 3'h1;
		wt(1'b0);
		serial_slave <= 3'h1;
		wt(1'b1);
		rst(2);
		power_mode <= 2'h3;
		bus(1'b1, ADDR_START0, 32'h08);
		pin_int <= 8'h08;
		irq_enable <= 32'h08;
		irq_pending <= 32'h08;
		u_wrc_ext_model.press_wake(2);
		wt(1'b0);
		bus(1'b1, ADDR_WAKEPIN, 32'h4);
		wt(1'b1);
		u_wrc_ext_model.press_wake(9);
		$display("test timer, serial, pin wake done");

		rst(2);
		bus(1'b1, ADDR_CLKSEL, 32'h1);
		repeat (4) @(posedge clk);
		chk(clk_select, 2'h0);
		clk_stable <= 2'h2;
		repeat (4) @(posedge clk);
		chk(clk_select, 2'h1);
		chk({jtag_bscan_en, swd_en}, 2'h1);
		u_wrc_ext_model.scan_enter();
		chk({jtag_bscan_en, swd_en, chip_reset}, 3'h5);
		u_wrc_ext_model.scan_exit();
		wait_rst();
		repeat (2) @(posedge clk);
		chk({jtag_bscan_en, swd_en}, 2'h1);
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h4, 32'h4);
		por_n <= 1'b0;
		repeat (3) @(posedge clk);
		chk(chip_reset, 1'b1);
		por_n <= 1'b1;
		wait_rst();
		bus(1'b0, ADDR_STATUS, 32'h0);
		chk(rd & 32'h10, 32'h10);
		$display("test clock and debug done");
		wrap_up();
	end
endmodule

//--- rtl/wrc_pkg.sv
// package: constants and types for the wake-up and reset control block
package wrc_pkg;

	// ==========================================================
	// register map (byte addresses, word aligned)
	localparam logic [5:0] ADDR_START0    = 6'h00;
	localparam logic [5:0] ADDR_START1    = 6'h04;
	localparam logic [5:0] ADDR_BROWNOUT  = 6'h08;
	localparam logic [5:0] ADDR_SLEEPCFG  = 6'h0c;
	localparam logic [5:0] ADDR_WDMODE    = 6'h10;
	localparam logic [5:0] ADDR_LPCLKEN   = 6'h14;
	localparam logic [5:0] ADDR_WKTCTRL   = 6'h18;
	localparam logic [5:0] ADDR_WAKEPIN   = 6'h1c;
	localparam logic [5:0] ADDR_POWER     = 6'h20;
	localparam logic [5:0] ADDR_STATUS    = 6'h24;
	localparam logic [5:0] ADDR_CLKSEL    = 6'h28;
	localparam logic [5:0] ADDR_PERIPH    = 6'h2c;

	// ==========================================================
	// field positions
	localparam int START1_BROWNOUT = 0;
	localparam int START1_WDT      = 1;
	localparam int START1_WKT      = 2;
	localparam int START1_SER0     = 3;
	localparam int NUM_SER         = 3;
	localparam int BO_LEVEL_LSB    = 0;
	localparam int BO_INT_EN       = 2;
	localparam int BO_RST_EN       = 3;
	localparam int SLEEP_BO_PWR    = 0;
	localparam int SLEEP_LPO_PWR   = 1;
	localparam int WD_ENABLE       = 0;
	localparam int WD_RESET_EN     = 1;
	localparam int WD_INT_EN       = 2;
	localparam int WD_FED          = 3;
	localparam int WKT_LP_SEL      = 0;
	localparam int WKT_STARTED     = 1;
	localparam int NUM_PIN_INT     = 8;
	localparam int NUM_WAKE_PIN    = 8;

	// ==========================================================
	// reset values and counts
	localparam logic [31:0] RST_ZERO       = 32'h0;
	localparam logic [1:0]  RST_CLK_FRO    = 2'h0;
	localparam logic [31:0] BOOT_ADDR      = 32'h0;
	localparam int          CLK_MHZ        = 200;
	localparam int          RST_PULSE_NS   = 50;
	// shortest external reset pulse in cycles, rounded up
	localparam int          RST_PULSE_CYC  = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
	localparam logic [3:0]  RST_STRETCH    = 4'(RST_PULSE_CYC);

	typedef enum logic [1:0] {WRC_RUN, WRC_SLEEP, WRC_DEEP, WRC_DPD} wrc_mode_t;
	typedef enum {WRC_S_RESET, WRC_S_ACTIVE, WRC_S_LOW} wrc_state_t;

	// wake causes gathered into one carrier
	typedef struct packed {
		logic       pin_int;
		logic       bo_int;
		logic       bo_rst;
		logic       wd_int;
		logic       wd_rst;
		logic       self_wake_timer;
		logic       serial;
		logic       wake_pin;
	} wrc_wake_t;

endpackage

//--- rtl/wrc_sync.sv
// two-stage synchroniser for the wake request
`timescale 1ns/1ps
module wrc_sync
	import wrc_pkg::*;
(
	input  wire logic clk,
	input  wire logic resetn,
	input  wire logic ce,
	input  wire logic d,
	output logic      q
);
	logic meta;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			meta <= 1'b0;
			q    <= 1'b0;
		end
		else if (ce)
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule

//--- rtl/wrc_top.sv
// wake-up and reset control: wake gating, reset collection, brownout, debug select
// Contract
// - sleep: any interrupt enabled in interrupt controller resumes execution
// - deep-sleep (WRC_DEEP): pin interrupt wakes if enabled in controller and start-logic 0
// - brownout interrupt wakes if enabled everywhere and detector powered in sleep
// - brownout reset wakes if reset enabled and detector powered in sleep
// - watchdog interrupt wakes if enabled, running, fed, interrupt on, oscillator powered
// - watchdog reset wakes if running, fed, reset enabled, oscillator powered
// - self-wake timer wakes if enabled, low-power clock on and selected, started
// - serial peripheral wakes only in slave mode, enabled; host supplies its clock
// - deep power-down leaves only through enabled wake pins
// - start on free-running oscillator; other clocks only once stable
// - four reset sources; any restarts oscillator and initialises flash controller
// - after resetn all registers predefined; the four reset sources preset only the clock select; fetch starts at address zero
// - brownout: one reset level, three interrupt levels, interrupt below level
// - brownout signal readable in a status register
// - one brownout level may force full chip reset
// - reset pin low selects boundary scan, high serial-wire; debug off in reset
// - boundary scan gives no processor debug access
// - deep-mode wake interrupts need wake enable and controller enable
`timescale 1ns/1ps
module wrc_top
	import wrc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	input  wire logic        ce,
	input  wire logic [5:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	input  wire logic [3:0]  avs_byteenable,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic [1:0]  power_mode,
	input  wire logic [31:0] irq_pending,
	input  wire logic [31:0] irq_enable,
	input  wire logic [7:0]  pin_int,
	input  wire logic [2:0]  bo_below_int_level,
	input  wire logic        bo_below_rst_level,
	input  wire logic        wd_int,
	input  wire logic        wd_rst,
	input  wire logic        wkt_timeout,
	input  wire logic [2:0]  serial_int,
	input  wire logic [2:0]  serial_slave,
	input  wire logic [7:0]  wake_pin_n,
	input  wire logic        reset_pin_n,
	input  wire logic        por_n,
	input  wire logic [1:0]  clk_stable,
	output logic             wake_core,
	output logic             chip_reset,
	output logic             fro_start,
	output logic             flash_init,
	output logic [31:0]      fetch_addr,
	output logic [1:0]       clk_select,
	output logic             bo_irq,
	output logic             jtag_bscan_en,
	output logic             swd_en
);
	// ==========================================================
	// registers
	logic [7:0]  start0;
	logic [5:0]  start1;
	logic [3:0]  bo_ctrl;
	logic [1:0]  sleep_cfg;
	logic [3:0]  wd_mode;
	logic        lp_clk_en;
	logic [1:0]  wkt_ctrl;
	logic [7:0]  wake_pin_en;
	logic [1:0]  clk_req;
	logic [2:0]  periph_ie;
	logic [3:0]  rst_cause;
	logic [3:0]  rst_cnt;
	logic        acked;
	wrc_mode_t   mode;
	wrc_wake_t   cause;
	logic        wake_raw;
	logic        wake_sync;
	logic        bo_flag;
	logic        any_rst;
	logic        deep_mode;
	logic        bo_rst_live;
	logic        wd_rst_live;
	logic [3:0]  rst_set;
	logic [3:0]  rst_clr;
	logic [31:0] next_readdata;
	logic        wr;
	logic        rd;

	assign mode = wrc_mode_t'(power_mode);
	// writes land on the edge that ends the wait
	assign wr   = avs_write & acked & ce;
	assign rd   = avs_read & avs_waitrequest & ce;

	// ==========================================================
	// bus slave: one wait cycle, then answer
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			acked <= 1'b0;
		else if (ce)
			acked <= (avs_read | avs_write) & ~acked;
	end

	always_comb
	begin
		avs_waitrequest = ~acked;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			start0      <= 8'h00;
			start1      <= 6'h00;
			bo_ctrl     <= 4'h0;
			sleep_cfg   <= 2'h0;
			wd_mode     <= 4'h0;
			lp_clk_en   <= 1'b0;
			wkt_ctrl    <= 2'h0;
			wake_pin_en <= 8'h00;
			periph_ie   <= 3'h0;
		end
		else if (wr && chip_reset == 1'b0 && avs_byteenable[0])
		begin
			unique case (avs_address)
				ADDR_START0:   start0      <= avs_writedata[7:0];
				ADDR_START1:   start1      <= avs_writedata[5:0];
				ADDR_BROWNOUT: bo_ctrl     <= avs_writedata[3:0];
				ADDR_SLEEPCFG: sleep_cfg   <= avs_writedata[1:0];
				ADDR_WDMODE:   wd_mode     <= avs_writedata[3:0];
				ADDR_LPCLKEN:  lp_clk_en   <= avs_writedata[0];
				ADDR_WKTCTRL:  wkt_ctrl    <= avs_writedata[1:0];
				ADDR_WAKEPIN:  wake_pin_en <= avs_writedata[7:0];
				ADDR_PERIPH:   periph_ie   <= avs_writedata[2:0];
				default:       ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			clk_req <= RST_CLK_FRO;
		else if (ce && chip_reset)
			clk_req <= RST_CLK_FRO;
		else if (wr && avs_address == ADDR_CLKSEL && avs_byteenable[0])
			clk_req <= avs_writedata[1:0];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			clk_select <= RST_CLK_FRO;
		else if (ce && chip_reset)
			clk_select <= RST_CLK_FRO;
		else if (ce && (clk_req == RST_CLK_FRO || clk_stable[clk_req[0]]))
			clk_select <= clk_req;
	end

	always_comb
	begin
		next_readdata = RST_ZERO;
		unique case (avs_address)
			ADDR_START0:   next_readdata[7:0] = start0;
			ADDR_START1:   next_readdata[5:0] = start1;
			ADDR_BROWNOUT: next_readdata[3:0] = bo_ctrl;
			ADDR_SLEEPCFG: next_readdata[1:0] = sleep_cfg;
			ADDR_WDMODE:   next_readdata[3:0] = wd_mode;
			ADDR_LPCLKEN:  next_readdata[0]   = lp_clk_en;
			ADDR_WKTCTRL:  next_readdata[1:0] = wkt_ctrl;
			ADDR_WAKEPIN:  next_readdata[7:0] = wake_pin_en;
			ADDR_STATUS:   next_readdata[5:0] = {rst_cause, bo_below_rst_level, bo_flag};
			ADDR_CLKSEL:   next_readdata[1:0] = clk_select;
			ADDR_PERIPH:   next_readdata[2:0] = periph_ie;
			default:       next_readdata = RST_ZERO;
		endcase
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			avs_readdata <= RST_ZERO;
		else if (rd)
			avs_readdata <= next_readdata;
	end

	// ==========================================================
	// brownout: three interrupt levels, one reset level
	// interrupt below selected level
	always_comb
	begin
		bo_flag = (bo_ctrl[1:0] != 2'h0) && bo_below_int_level[bo_ctrl[1:0] - 2'h1];
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			bo_irq <= 1'b0;
		else if (ce)
			bo_irq <= bo_flag & bo_ctrl[BO_INT_EN];
	end

	// ==========================================================
	// wake source gating
	always_comb
	begin
		cause.pin_int  = |(pin_int & start0 & irq_enable[7:0]);
		cause.bo_int   = bo_flag & start1[START1_BROWNOUT] & irq_enable[8]
			& bo_ctrl[BO_INT_EN] & sleep_cfg[SLEEP_BO_PWR];
		cause.bo_rst   = bo_below_rst_level & bo_ctrl[BO_RST_EN] & sleep_cfg[SLEEP_BO_PWR];
		cause.wd_int   = wd_int & start1[START1_WDT] & irq_enable[9] & wd_mode[WD_ENABLE]
			& wd_mode[WD_FED] & wd_mode[WD_INT_EN] & sleep_cfg[SLEEP_LPO_PWR];
		cause.wd_rst   = wd_rst & wd_mode[WD_ENABLE] & wd_mode[WD_FED]
			& wd_mode[WD_RESET_EN] & sleep_cfg[SLEEP_LPO_PWR];
		cause.self_wake_timer      = wkt_timeout & start1[START1_WKT] & irq_enable[10] & lp_clk_en
			& wkt_ctrl[WKT_LP_SEL] & wkt_ctrl[WKT_STARTED];
		cause.serial   = |(serial_int & serial_slave & periph_ie & start1[START1_SER0 +: NUM_SER]
			& irq_enable[13:11]);
		cause.wake_pin = |(~wake_pin_n & wake_pin_en);
	end

	always_comb
	begin
		unique case (mode)
			WRC_RUN:   wake_raw = 1'b0;
			WRC_SLEEP: wake_raw = |(irq_pending & irq_enable);
			WRC_DEEP:  wake_raw = cause.pin_int | cause.bo_int | cause.bo_rst | cause.wd_int
				| cause.wd_rst | cause.self_wake_timer | cause.serial;
			WRC_DPD:   wake_raw = cause.wake_pin;
		endcase
	end

	wrc_sync u_sync (
		.clk    (clk),
		.resetn (resetn),
		.ce     (ce),
		.d      (wake_raw),
		.q      (wake_sync)
	);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			wake_core <= 1'b0;
		else if (ce)
			wake_core <= wake_sync;
	end

	// ==========================================================
	// reset collection
	// four reset sources
	// deep modes: only powered detectors reset
	always_comb
	begin
		deep_mode   = (mode == WRC_DEEP) || (mode == WRC_DPD);
		bo_rst_live = bo_below_rst_level & bo_ctrl[BO_RST_EN]
			& (~deep_mode | sleep_cfg[SLEEP_BO_PWR]);
		wd_rst_live = wd_rst & wd_mode[WD_ENABLE] & wd_mode[WD_RESET_EN]
			& (~deep_mode | sleep_cfg[SLEEP_LPO_PWR]);
		rst_set     = {bo_rst_live, ~por_n, wd_rst_live, ~reset_pin_n};
		rst_clr     = (wr && avs_address == ADDR_STATUS) ? avs_writedata[5:2] : 4'h0;
		any_rst     = |rst_set;
	end

	// a new cause wins over a clear in the same cycle
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rst_cause <= 4'h0;
		else if (ce)
			rst_cause <= (rst_cause & ~rst_clr) | rst_set;
	end

	// stretch, then release; fetch address held at zero
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			rst_cnt <= RST_STRETCH;
		else if (ce && any_rst)
			rst_cnt <= RST_STRETCH;
		else if (ce && rst_cnt != 4'h0)
			rst_cnt <= rst_cnt - 4'h1;
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			chip_reset <= 1'b1;
			fro_start  <= 1'b1;
			flash_init <= 1'b1;
			fetch_addr <= BOOT_ADDR;
		end
		else if (ce)
		begin
			chip_reset <= any_rst | (rst_cnt != 4'h0);
			fro_start  <= any_rst | fro_start & (rst_cnt != 4'h0);
			flash_init <= any_rst;
			fetch_addr <= BOOT_ADDR;
		end
	end

	// ==========================================================
	// debug selection
	// pin level selects test port
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			jtag_bscan_en <= 1'b0;
			swd_en        <= 1'b0;
		end
		else if (ce)
		begin
			jtag_bscan_en <= ~reset_pin_n;
			swd_en        <= reset_pin_n & ~any_rst & ~chip_reset;
		end
	end

	// ==========================================================
	// checks
	property p_bscan_nodebug;
		@(posedge clk) disable iff (!resetn) jtag_bscan_en |-> !swd_en;
	endproperty
	a_bscan_nodebug: assert property (p_bscan_nodebug) else $error("debug with scan");

	property p_dpd_pin;
		@(posedge clk) disable iff (!resetn)
		ce && mode == WRC_DPD && $stable(mode) && !cause.wake_pin ##1 ce[*2] |-> !wake_sync;
	endproperty
	a_dpd_pin: assert property (p_dpd_pin) else $error("deep power-down woke without pin");

	sequence s_wake_in;
		ce && wake_raw ##1 ce && wake_raw ##1 ce;
	endsequence
	property p_wake_sync;
		@(posedge clk) disable iff (!resetn) s_wake_in |=> wake_core || !ce;
	endproperty
	a_wake_sync: assert property (p_wake_sync) else $error("wake not released");

	property p_rst_reset;
		@(posedge clk) disable iff (!resetn) ce && any_rst |=> chip_reset && flash_init;
	endproperty
	a_rst_reset: assert property (p_rst_reset) else $error("reset source ignored");

	property p_swd_off;
		@(posedge clk) disable iff (!resetn) chip_reset |-> ##1 (!swd_en || !ce);
	endproperty
	a_swd_off: assert property (p_swd_off) else $error("debug in reset");

	property p_fetch0;
		@(posedge clk) disable iff (!resetn) $fell(chip_reset) |-> fetch_addr == BOOT_ADDR;
	endproperty
	a_fetch0: assert property (p_fetch0) else $error("fetch not zero");

	property p_clk_stable;
		@(posedge clk) disable iff (!resetn)
		$changed(clk_select) && clk_select != RST_CLK_FRO |-> $past(clk_stable[clk_req[0]]);
	endproperty
	a_clk_stable: assert property (p_clk_stable) else $error("unstable clock selected");

	property p_bo_irq;
		@(posedge clk) disable iff (!resetn) ce && bo_flag && bo_ctrl[BO_INT_EN] |=> bo_irq;
	endproperty
	a_bo_irq: assert property (p_bo_irq) else $error("brownout irq missing");
endmodule
